//--- verilog/adcsto_pkg.sv
/*
 * Package for the ADC sample-time and preempted-offset block: register
 * indices, field layouts, reset values and sample-duration table.
 * Assumes a 32-bit register port with one register per index.
 */
package adcsto_pkg;
    // ****************
    // register map
    // ****************
    localparam logic [3:0] ADCSTO_IDX_SAMPLE_TIME = 4'h0;
    localparam logic [3:0] ADCSTO_IDX_OFFSET_1 = 4'h1;
    localparam logic [3:0] ADCSTO_IDX_OFFSET_2 = 4'h2;
    localparam logic [3:0] ADCSTO_IDX_OFFSET_3 = 4'h3;
    localparam logic [3:0] ADCSTO_IDX_OFFSET_4 = 4'h4;
    localparam logic [3:0] ADCSTO_IDX_STATUS = 4'h5;
    localparam int ADCSTO_ADDR_W = 4;

    // ****************
    // fields
    // ****************
    localparam int ADCSTO_NCHAN = 10;
    localparam int ADCSTO_CODE_W = 3;
    localparam int ADCSTO_CHAN_W = 4;
    localparam int ADCSTO_SPT_W = 30;
    localparam int ADCSTO_NPRE = 4;
    localparam int ADCSTO_DATA_W = 12;
    localparam int ADCSTO_CNT_W = 8;
    localparam logic [29:0] ADCSTO_SPT_RESET = 30'h0000_0000;
    localparam logic [11:0] ADCSTO_OFS_RESET = 12'h000;

    // ****************
    // sample durations, whole cycles; the half cycle is the final edge
    // ****************
    localparam logic [7:0] ADCSTO_DUR_000 = 8'h01;
    localparam logic [7:0] ADCSTO_DUR_001 = 8'h07;
    localparam logic [7:0] ADCSTO_DUR_010 = 8'h0d;
    localparam logic [7:0] ADCSTO_DUR_011 = 8'h1c;
    localparam logic [7:0] ADCSTO_DUR_100 = 8'h29;
    localparam logic [7:0] ADCSTO_DUR_101 = 8'h37;
    localparam logic [7:0] ADCSTO_DUR_110 = 8'h47;
    localparam logic [7:0] ADCSTO_DUR_111 = 8'hef;

    typedef enum logic [1:0] {
        ADCSTO_IDLE = 2'b00,
        ADCSTO_SAMPLE = 2'b01,
        ADCSTO_WAIT = 2'b11
    } adcsto_state_t;
endpackage

//--- verilog/adcsto_dur_lut.sv
/*
 * Sample-time code to sampling duration in whole clock cycles.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
module adcsto_dur_lut
    import adcsto_pkg::*;
(
    input wire logic [2:0] code,
    output logic [7:0] cycles
);
    always_comb begin
        unique case (code)
            3'h0: cycles = ADCSTO_DUR_000;
            3'h1: cycles = ADCSTO_DUR_001;
            3'h2: cycles = ADCSTO_DUR_010;
            3'h3: cycles = ADCSTO_DUR_011;
            3'h4: cycles = ADCSTO_DUR_100;
            3'h5: cycles = ADCSTO_DUR_101;
            3'h6: cycles = ADCSTO_DUR_110;
            3'h7: cycles = ADCSTO_DUR_111;
        endcase
    end
endmodule
`default_nettype wire

//--- verilog/adcsto_offset_sub.sv
/*
 * Offset subtractor: raw conversion minus the channel offset.
 * Wraps modulo 2^12, like the stored result; no saturation.
 */
`timescale 1ns/10ps
`default_nettype none
module adcsto_offset_sub
    import adcsto_pkg::*;
(
    input wire logic [11:0] raw,
    input wire logic [11:0] offset,
    output logic [11:0] result
);
    assign result = raw - offset;
endmodule
`default_nettype wire

//--- verilog/adcsto_top.sv
/*
 * ADC sample-time selection for channels 0..9 and the four preempted
 * channel data offsets, with a sampling-phase counter and result store.
 * Assumes a plain register port and a converter front end that pulses
 * conv_start with a channel, then later pulses raw_valid with data.
 */
// Decided for this implementation: the register addresses and the plain strobed port.
// Function
// - code selects 1.5 to 239.5 cycles
// - channels 9, 8 at bits 29:27, 26:24
// - channels 7, 6 at bits 23:21, 20:18
// - channels 5, 4 at bits 17:15, 14:12
// - channels 3, 2 at bits 11:9, 8:6
// - channels 1, 0 at bits 5:3, 2:0
// - bits 31:30 reserved, kept zero
// - result is raw minus channel offset
// - 12-bit offset field, upper bits zero
`timescale 1ns/10ps
`default_nettype none
module adcsto_top
    import adcsto_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic conv_start,
    input wire logic [3:0] conv_chan,
    output logic sampling,
    output logic sample_done,
    input wire logic raw_valid,
    input wire logic [1:0] raw_pre_sel,
    input wire logic [11:0] raw_data,
    output logic [11:0] result_data,
    output logic [1:0] result_sel,
    output logic result_valid
);
    // ****************
    // registers
    // ****************
    logic [29:0] sample_time_low_channels;
    logic [11:0] preempted_offset_value [ADCSTO_NPRE];
    adcsto_state_t state;
    logic [7:0] sample_cnt;
    logic [2:0] sel_code;
    logic [7:0] sel_cycles;
    logic [11:0] sub_result;
    logic [11:0] sel_offset;
    logic [31:0] next_rdata;

    // ****************
    // sample-time register write
    // ****************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sample_time_low_channels <= ADCSTO_SPT_RESET;
        end else if (wr && addr == ADCSTO_IDX_SAMPLE_TIME) begin
            // bits 31:30 are not stored, so they stay zero
            sample_time_low_channels <= wdata[ADCSTO_SPT_W-1:0];
        end
    end

    // ****************
    // offset registers, one per preempted channel
    // ****************
    genvar g;
    generate
        for (g = 0; g < ADCSTO_NPRE; g++) begin : g_ofs
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    preempted_offset_value[g] <= ADCSTO_OFS_RESET;
                end else if (wr && addr == ADCSTO_IDX_OFFSET_1 + 4'(g)) begin
                    preempted_offset_value[g] <= wdata[ADCSTO_DATA_W-1:0];
                end
            end
        end
    endgenerate

    // ****************
    // read path, data one cycle after the strobe
    // ****************
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (addr)
            ADCSTO_IDX_SAMPLE_TIME: begin
                // channel c occupies bits 3c+2:3c, 9 at the top
                next_rdata = {2'b00, sample_time_low_channels};
            end
            ADCSTO_IDX_OFFSET_1: begin
                next_rdata = {20'h00000, preempted_offset_value[0]};
            end
            ADCSTO_IDX_OFFSET_2: begin
                next_rdata = {20'h00000, preempted_offset_value[1]};
            end
            ADCSTO_IDX_OFFSET_3: begin
                next_rdata = {20'h00000, preempted_offset_value[2]};
            end
            ADCSTO_IDX_OFFSET_4: begin
                next_rdata = {20'h00000, preempted_offset_value[3]};
            end
            ADCSTO_IDX_STATUS: begin
                next_rdata = {22'h000000, state, sample_cnt};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ****************
    // sampling phase
    // ****************
    // channels above 9 live elsewhere; they take code 000 here
    always_comb begin
        if (conv_chan < 4'(ADCSTO_NCHAN)) begin
            sel_code = sample_time_low_channels[conv_chan*ADCSTO_CODE_W +: ADCSTO_CODE_W];
        end else begin
            sel_code = 3'h0;
        end
    end

    adcsto_dur_lut u_lut (
        .code(sel_code),
        .cycles(sel_cycles)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ADCSTO_IDLE;
            sample_cnt <= 8'h00;
            sampling <= 1'b0;
            sample_done <= 1'b0;
        end else begin
            sample_done <= 1'b0;
            unique case (state)
                ADCSTO_IDLE: begin
                    // a start while sampling or in the sample_done cycle is ignored
                    if (conv_start) begin
                        state <= ADCSTO_SAMPLE;
                        sample_cnt <= sel_cycles;
                        sampling <= 1'b1;
                    end
                end
                ADCSTO_SAMPLE: begin
                    if (sample_cnt == 8'h01) begin
                        state <= ADCSTO_WAIT;
                        sample_cnt <= 8'h00;
                        sampling <= 1'b0;
                        sample_done <= 1'b1;
                    end else begin
                        sample_cnt <= sample_cnt - 8'h01;
                    end
                end
                ADCSTO_WAIT: begin
                    state <= ADCSTO_IDLE;
                end
                default: begin
                    state <= ADCSTO_IDLE;
                    sampling <= 1'b0;
                end
            endcase
        end
    end

    // ****************
    // preempted result store
    // ****************
    assign sel_offset = preempted_offset_value[raw_pre_sel];

    adcsto_offset_sub u_sub (
        .raw(raw_data),
        .offset(sel_offset),
        .result(sub_result)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_data <= 12'h000;
            result_sel <= 2'b00;
            result_valid <= 1'b0;
        end else begin
            result_valid <= raw_valid;
            if (raw_valid) begin
                result_data <= sub_result;
                result_sel <= raw_pre_sel;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/adcsto_checker.sv
/* checker for adcsto_top: read data, sampling and result timing
   assumes one clock, mclk, and bind onto every adcsto_top */
`timescale 1ns/10ps
`default_nettype none
module adcsto_checker
    import adcsto_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic conv_start,
    input wire logic sampling,
    input wire logic sample_done,
    input wire logic raw_valid,
    input wire logic [1:0] raw_pre_sel,
    input wire logic [1:0] result_sel,
    input wire logic result_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (
        !$past(rd) |-> rdata == 32'h0) else $error("rdata not zero outside a read");
    a_spt_top_zero: assert property (
        $past(rd) && $past(addr) == ADCSTO_IDX_SAMPLE_TIME |-> rdata[31:30] == 2'h0)
        else $error("sample time bits 31:30 not zero");
    a_ofs_top_zero: assert property (
        $past(rd) && $past(addr) inside {[ADCSTO_IDX_OFFSET_1:ADCSTO_IDX_OFFSET_4]}
        |-> rdata[31:12] == 20'h0) else $error("offset bits 31:12 not zero");
    a_result_one_late: assert property (
        raw_valid |=> result_valid && result_sel == $past(raw_pre_sel))
        else $error("result not one cycle after raw");
    a_no_stray_result: assert property (
        result_valid |-> $past(raw_valid)) else $error("result without raw");
    a_start_taken: assert property (
        conv_start && !sampling && !sample_done && !$past(sample_done) |=> sampling)
        else $error("idle start not taken");
    a_done_ends_sample: assert property (
        sample_done |-> $past(sampling) && !sampling) else $error("done out of place");
    a_done_bounded: assert property (
        $rose(sampling) |-> ##[1:239] sample_done) else $error("sampling overran");
endmodule
bind adcsto_top adcsto_checker chk_u (.mclk, .rst, .addr, .rd, .rdata, .conv_start,
    .sampling, .sample_done, .raw_valid, .raw_pre_sel, .result_sel, .result_valid);
`default_nettype wire

//--- tb/adcsto_top_tb.sv
/* table-driven bench for adcsto_top: registers, sampling, results
   assumes the checker is bound by its own file */
`timescale 1ns/10ps
`default_nettype none
module adcsto_top_tb
    import adcsto_pkg::*;
;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e;} adcsto_row_t;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, conv_start = 1'b0, raw_valid = 1'b0;
    logic [3:0] addr = 4'h0, conv_chan = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v, spt;
    logic [1:0] raw_pre_sel = 2'h0, result_sel;
    logic [11:0] raw_data = 12'h000, result_data, e;
    logic sampling, sample_done, result_valid;
    int failures = 0, comparisons = 0, i;
    int dur[8] = '{1, 7, 13, 28, 41, 55, 71, 239};
    logic [11:0] ofs[4] = '{12'h020, 12'h800, 12'hfff, 12'h001};
    logic [11:0] raws[4] = '{12'h010, 12'h7ff, 12'h000, 12'habc};
    // last offset writes must match ofs
    adcsto_row_t rows[8] = '{'{4'h0, 32'hffffffff, 32'h3fffffff},
        '{4'h0, 32'h12345678, 32'h12345678}, '{4'h1, 32'hffffffff, 32'h00000fff},
        '{4'h1, 32'h00000020, 32'h00000020}, '{4'h2, 32'hfffff800, 32'h00000800},
        '{4'h3, 32'h00000fff, 32'h00000fff}, '{4'h4, 32'h00000001, 32'h00000001},
        '{4'h6, 32'hffffffff, 32'h00000000}};
    adcsto_top dut_u (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .conv_start, .conv_chan,
        .sampling, .sample_done, .raw_valid, .raw_pre_sel, .raw_data, .result_data,
        .result_sel, .result_valid);
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ****************
    // tasks
    // ****************
    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // counts edges after the start is taken until done shows
    task automatic conv(input logic [3:0] ch, input int n);
        int k;
        @(posedge mclk);
        conv_start <= 1'b1;
        conv_chan <= ch;
        @(posedge mclk);
        conv_start <= 1'b0;
        for (k = 1; k < 300; k++) begin
            @(posedge mclk);
            #1;
            if (sample_done === 1'b1) break;
        end
        chk("sample cycles", k, n);
        if (k >= 300) stop_test();
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            rd_reg(4'(i), v);
            chk("reset value", v, 32'h0);
        end
        $display("test reset done");
        foreach (rows[j]) begin
            wr_reg(rows[j].a, rows[j].d);
            rd_reg(rows[j].a, v);
            chk("register", v, rows[j].e);
        end
        $display("test registers done");
        spt = 32'h0;
        for (i = 0; i < 10; i++) spt = spt | (32'(i % 8) << (3 * i));
        wr_reg(4'h0, spt);
        for (i = 0; i < 10; i++) conv(4'(i), dur[i % 8]);
        conv(4'hc, dur[0]);
        $display("test sampling done");
        // back to back raw words, checked one edge late
        for (i = 0; i <= 4; i++) begin
            @(posedge mclk);
            raw_valid <= (i < 4);
            raw_pre_sel <= 2'(i);
            raw_data <= raws[i % 4];
            #1;
            if (i > 0) begin
                e = raws[i - 1] - ofs[i - 1];
                chk("result data", result_data, e);
                chk("result sel", result_sel, i - 1);
                chk("result valid", result_valid, 32'h1);
            end
        end
        @(posedge mclk);
        #1;
        chk("result valid low", result_valid, 32'h0);
        $display("test results done");
        stop_test();
    end
endmodule
`default_nettype wire
